// [ppsc_clk_if.sv]
`timescale 1ns/1ps
interface ppsc_clk_if;
   logic [ppsc_pkg::PW-1:0] period;
   logic [ppsc_pkg::PW-1:0] phase;
   ppsc_pkg::ppsc_share_t mode;
   logic sync_rise;
   logic tick;
   logic [ppsc_pkg::PW-1:0] pos;
   logic share_oe;
   modport ctl (output period, phase, mode, sync_rise, input tick, pos, share_oe);
   modport gen (input period, phase, mode, sync_rise, output tick, pos, share_oe);
endinterface : ppsc_clk_if

// [ppsc_clock_gen.sv]
`timescale 1ns/1ps
module ppsc_clock_gen
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Control side
   ppsc_clk_if.gen clk_if
);
   typedef struct packed {
      logic [ppsc_pkg::PW-1:0] pos;
      logic [ppsc_pkg::PW-1:0] dly;
      logic dly_run;
      logic tick;
      logic oe;
   } ppsc_cg_t;

   ppsc_cg_t q;
   ppsc_cg_t next_q;

   // Period counter, slave restart and phase delay
   always_comb
   begin
      next_q = q;
      next_q.tick = 1'b0;
      next_q.pos = q.pos + 1'b1;
      if (q.pos >= clk_if.period - 1'b1)
      begin
         next_q.pos = '0;
         next_q.tick = 1'b1;
      end
      if (q.dly_run)
      begin
         next_q.dly = q.dly - 1'b1;
         if (q.dly == '0)
         begin
            next_q.pos = '0;
            next_q.tick = 1'b1;
            next_q.dly_run = 1'b0;
         end
      end
      if (clk_if.mode == ppsc_pkg::SH_SLAVE && clk_if.sync_rise)
      begin
         next_q.pos = '0;
         next_q.tick = 1'b1;
         next_q.dly_run = 1'b0;
      end
      if (clk_if.mode == ppsc_pkg::SH_SHIFT && clk_if.sync_rise)
      begin
         next_q.dly = clk_if.phase;
         next_q.dly_run = 1'b1;
      end
      next_q.oe = (clk_if.mode == ppsc_pkg::SH_MASTER) && (next_q.pos >= (clk_if.period >> 1));
   end

   // State register
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         q <= '0;
      else
         q <= next_q;
   end

   assign clk_if.tick = q.tick;
   assign clk_if.pos = q.pos;
   assign clk_if.share_oe = q.oe;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_share_release: assert property (
      clk_if.mode != ppsc_pkg::SH_MASTER |=> !q.oe || $past(clk_if.mode) == ppsc_pkg::SH_MASTER)
      else $error("share pin driven outside master role");
   a_master_half: assert property (
      $past(clk_if.mode) == ppsc_pkg::SH_MASTER && clk_if.mode == ppsc_pkg::SH_MASTER
      && $stable(clk_if.period) |-> q.oe == (q.pos >= (clk_if.period >> 1)))
      else $error("master share clock not half duty");
endmodule : ppsc_clock_gen

// [ppsc_control.sv]
// Operation
// - Count consecutive over-limit switching cycles; past 500 enter hiccup.
// - Hiccup stops regulation 500 switching cycles, then restarts automatically.
// - After restart, regulate only once soft-start flag rises.
// - Switching period programmable between 50 kHz and 300 kHz.
// - High or floating share level: master, own clock driven out.
// - Master share clock has about half duty.
// - Low share level: slave, locked to the external clock edge.
// - Middle share level: lock to external clock shifted by set delay.
// - Duty capped at programmed ceiling, at most 98 percent.
// - Trip input low disables, drives both outputs low, resets ramp.
// - Trip input high again lets switching restart.
// - Overtemperature stops switching, drives outputs low, discharges ramp.
// - Overtemperature clearing restarts the control loop.
// - Topology flag low selects boost, high selects buck.
// - Topology latched on rail and trip rising edges, held otherwise.
// - Boost switches low side only; buck switches high side only.
// - Error flag low disables drives; error high runs at ceiling.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module ppsc_control
#(
   parameter int unsigned HICCUP_LIMIT = ppsc_pkg::HICCUP_LIMIT,
   parameter int unsigned HICCUP_CYCLES = ppsc_pkg::HICCUP_CYCLES
)
(
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_SYS_RST,
   // Comparator flags
   input wire logic I_ENABLE,
   input wire logic I_LOW_SUPPLY_LOCK,
   input wire logic I_INTERNAL_RAIL_GOOD,
   input wire logic I_OVER_LIMIT,
   input wire logic I_SS_ABOVE,
   input wire logic I_TRIP_OK,
   input wire logic I_OVERTEMP_TRIP,
   input wire logic I_TOPOLOGY_BUCK,
   input wire logic I_SHARE_CONFIG_MASTER,
   input wire logic I_SHARE_CONFIG_SLAVE,
   input wire logic I_SHARE_CONFIG_SHIFT,
   input wire logic I_ERROR_LOW,
   input wire logic I_ERROR_HIGH,
   // Clock-share pin
   input wire logic I_SHARE_CLK,
   output logic O_SHARE_CLK,
   output logic O_SHARE_CLK_OE,
   // Drive outputs
   output logic O_HIGH_SIDE_DRIVE,
   output logic O_LOW_SIDE_DRIVE,
   output logic O_SS_DISCHARGE,
   // AHB-Lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP
);
   localparam int PW = ppsc_pkg::PW;
   localparam int CW = ppsc_pkg::CW;
   localparam int NF = ppsc_pkg::NFLAG;

   typedef struct packed {
      logic [NF-1:0] s1;
      logic [NF-1:0] s2;
      logic [NF-1:0] s3;
      ppsc_pkg::ppsc_state_t st;
      logic [CW-1:0] cnt;
      logic buck;
      logic hi;
      logic lo;
      logic ssd;
      logic sw_en;
      logic [PW-1:0] period;
      logic [6:0] ceil;
      logic [6:0] duty;
      logic [PW-1:0] phase;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hready;
   } ppsc_ctl_t;

   ppsc_ctl_t q;
   ppsc_ctl_t next_q;
   ppsc_clk_if clk_if ();

   logic [NF-1:0] flags;
   logic dis;
   logic tick;
   logic [6:0] duty_eff;
   logic [PW+6:0] on_prod;
   logic [PW-1:0] on_cnt;
   logic pwm_on;
   logic rail_rise;
   logic trip_rise;

   // Clamp a written period into the legal range
   function automatic logic [PW-1:0] ppsc_clamp_period(input logic [PW-1:0] v);
      if (v < ppsc_pkg::PERIOD_MIN)
         return ppsc_pkg::PERIOD_MIN;
      else if (v > ppsc_pkg::PERIOD_MAX)
         return ppsc_pkg::PERIOD_MAX;
      return v;
   endfunction : ppsc_clamp_period

   // Clamp a percentage to a limit
   function automatic logic [6:0] ppsc_clamp_pct(input logic [6:0] v, input logic [6:0] lim);
      return (v > lim) ? lim : v;
   endfunction : ppsc_clamp_pct

   // Raw flag vector in index order
   assign flags = {I_ENABLE, I_SHARE_CLK, I_ERROR_HIGH, I_ERROR_LOW, I_SHARE_CONFIG_SHIFT,
                   I_SHARE_CONFIG_SLAVE, I_SHARE_CONFIG_MASTER, I_INTERNAL_RAIL_GOOD,
                   I_TOPOLOGY_BUCK, I_OVERTEMP_TRIP, I_TRIP_OK, I_SS_ABOVE, I_OVER_LIMIT};

   // Edges from synchronised flags; disable causes from them, the control bit and the raw low supply lock input
   assign rail_rise = q.s2[ppsc_pkg::F_RAIL] && !q.s3[ppsc_pkg::F_RAIL];
   assign trip_rise = q.s2[ppsc_pkg::F_TRIP_OK] && !q.s3[ppsc_pkg::F_TRIP_OK];
   assign tick = clk_if.tick;
   assign dis = !q.s2[ppsc_pkg::F_EN] || !q.sw_en || !q.s2[ppsc_pkg::F_TRIP_OK]
                || q.s2[ppsc_pkg::F_OTEMP] || !q.s2[ppsc_pkg::F_RAIL] || I_LOW_SUPPLY_LOCK;

   // Clock generator hookup and share role
   assign clk_if.period = q.period;
   assign clk_if.phase = q.phase;
   assign clk_if.sync_rise = q.s2[ppsc_pkg::F_SYNC] && !q.s3[ppsc_pkg::F_SYNC];
   always_comb
   begin
      if (q.s2[ppsc_pkg::F_SH_MST])
         clk_if.mode = ppsc_pkg::SH_MASTER;
      else if (q.s2[ppsc_pkg::F_SH_SFT] && !q.s2[ppsc_pkg::F_SH_SLV])
         clk_if.mode = ppsc_pkg::SH_SHIFT;
      else
         clk_if.mode = ppsc_pkg::SH_SLAVE;
   end

   ppsc_clock_gen u_clock_gen
   (
      .i_clk(I_REF_CLK),
      .i_rst(I_SYS_RST),
      .clk_if(clk_if)
   );

   // Duty compare against the period position
   always_comb
   begin
      if (q.s2[ppsc_pkg::F_COMP_HI])
         duty_eff = q.ceil;
      else
         duty_eff = ppsc_clamp_pct(q.duty, q.ceil);
      on_prod = q.period * duty_eff;
      on_cnt = PW'(on_prod / ppsc_pkg::DUTY_FULL);
      pwm_on = (q.st == ppsc_pkg::ST_RUN) && !dis && !q.s2[ppsc_pkg::F_COMP_LO]
               && (clk_if.pos < on_cnt);
   end

   // Next state of control, protection and registers
   always_comb
   begin
      next_q = q;
      next_q.s1 = flags;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      if (rail_rise || trip_rise)
         next_q.buck = q.s2[ppsc_pkg::F_BUCK];
      if (dis)
      begin
         next_q.st = ppsc_pkg::ST_OFF;
         next_q.cnt = '0;
      end
      else
      begin
         unique case (q.st)
            ppsc_pkg::ST_OFF:
            begin
               next_q.st = ppsc_pkg::ST_RAMP;
               next_q.cnt = '0;
            end
            ppsc_pkg::ST_RAMP:
            begin
               if (q.s2[ppsc_pkg::F_SS_UP])
                  next_q.st = ppsc_pkg::ST_RUN;
            end
            ppsc_pkg::ST_RUN:
            begin
               if (tick)
               begin
                  if (!q.s2[ppsc_pkg::F_OVER])
                     next_q.cnt = '0;
                  else if (q.cnt >= CW'(HICCUP_LIMIT))
                  begin
                     next_q.st = ppsc_pkg::ST_HICCUP;
                     next_q.cnt = '0;
                  end
                  else
                     next_q.cnt = q.cnt + 1'b1;
               end
            end
            ppsc_pkg::ST_HICCUP:
            begin
               if (tick)
               begin
                  if (q.cnt >= CW'(HICCUP_CYCLES - 1))
                  begin
                     next_q.st = ppsc_pkg::ST_RAMP;
                     next_q.cnt = '0;
                  end
                  else
                     next_q.cnt = q.cnt + 1'b1;
               end
            end
         endcase
      end
      // discharge ramp while off or in hiccup
      next_q.ssd = (next_q.st == ppsc_pkg::ST_OFF) || (next_q.st == ppsc_pkg::ST_HICCUP);
      // route PWM to one side only
      next_q.hi = pwm_on && q.buck;
      next_q.lo = pwm_on && !q.buck;
      // Bus data phase write
      next_q.wr_pend = 1'b0;
      if (q.wr_pend)
      begin
         unique case (q.wr_addr)
            ppsc_pkg::A_CTRL: next_q.sw_en = I_HWDATA[0];
            ppsc_pkg::A_PERIOD: next_q.period = ppsc_clamp_period(I_HWDATA[PW-1:0]);
            // ceiling held at or below 98
            ppsc_pkg::A_CEIL: next_q.ceil = ppsc_clamp_pct(I_HWDATA[6:0], ppsc_pkg::DUTY_MAX);
            ppsc_pkg::A_DUTY: next_q.duty = ppsc_clamp_pct(I_HWDATA[6:0], ppsc_pkg::DUTY_FULL);
            ppsc_pkg::A_PHASE: next_q.phase = I_HWDATA[PW-1:0];
            default: next_q.wr_pend = 1'b0;
         endcase
      end
      // Bus address phase
      next_q.hready = 1'b1;
      if (I_HSEL && I_HTRANS[1] && I_HREADY)
      begin
         next_q.wr_pend = I_HWRITE && (I_HSIZE == ppsc_pkg::SIZE_WORD);
         next_q.wr_addr = I_HADDR[7:0];
         next_q.hrdata = '0;
         if (!I_HWRITE && I_HADDR[31:8] == 24'h000000)
         begin
            unique case (I_HADDR[7:0])
               ppsc_pkg::A_CTRL: next_q.hrdata[0] = q.sw_en;
               ppsc_pkg::A_PERIOD: next_q.hrdata[PW-1:0] = q.period;
               ppsc_pkg::A_CEIL: next_q.hrdata[6:0] = q.ceil;
               ppsc_pkg::A_DUTY: next_q.hrdata[6:0] = q.duty;
               ppsc_pkg::A_PHASE: next_q.hrdata[PW-1:0] = q.phase;
               ppsc_pkg::A_STATUS:
               begin
                  next_q.hrdata[1:0] = q.st;
                  next_q.hrdata[ppsc_pkg::ST_BUCK] = q.buck;
                  next_q.hrdata[ppsc_pkg::ST_MASTER] = (clk_if.mode == ppsc_pkg::SH_MASTER);
                  next_q.hrdata[ppsc_pkg::ST_CNT +: CW] = q.cnt;
                  next_q.hrdata[ppsc_pkg::ST_DIS] = dis;
               end
               default: next_q.hrdata = '0;
            endcase
         end
         if (I_HADDR[31:8] != 24'h000000)
            next_q.wr_pend = 1'b0;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SYS_RST)
      begin
         q <= '0;
         q.buck <= 1'b1;
         q.ssd <= 1'b1;
         q.sw_en <= 1'b1;
         q.period <= ppsc_pkg::PERIOD_DEF;
         q.ceil <= ppsc_pkg::DUTY_MAX;
         q.duty <= ppsc_pkg::DUTY_RST;
         q.phase <= ppsc_pkg::PHASE_RST;
         q.hready <= 1'b1;
      end
      else
         q <= next_q;
   end

   // Outputs straight from flip-flops; share clock level and bus response tied low
   assign O_HIGH_SIDE_DRIVE = q.hi;
   assign O_LOW_SIDE_DRIVE = q.lo;
   assign O_SS_DISCHARGE = q.ssd;
   assign O_SHARE_CLK = 1'b0;
   assign O_SHARE_CLK_OE = clk_if.share_oe;
   assign O_HRDATA = q.hrdata;
   assign O_HREADYOUT = q.hready;
   assign O_HRESP = 1'b0;

   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_SYS_RST);

   a_hiccup_entry: assert property (
      q.st == ppsc_pkg::ST_RUN && !dis && tick && q.s2[ppsc_pkg::F_OVER]
      && q.cnt == CW'(HICCUP_LIMIT) |=> q.st == ppsc_pkg::ST_HICCUP && q.cnt == '0)
      else $error("hiccup not entered after limit");
   a_hiccup_exit: assert property (
      q.st == ppsc_pkg::ST_HICCUP && !dis && tick && q.cnt == CW'(HICCUP_CYCLES - 1)
      |=> q.st == ppsc_pkg::ST_RAMP)
      else $error("hiccup did not end after its count");
   a_ramp_gate: assert property (
      q.st == ppsc_pkg::ST_RAMP && !q.s2[ppsc_pkg::F_SS_UP] |=> q.st != ppsc_pkg::ST_RUN)
      else $error("regulation began before soft-start threshold");
   a_period_range: assert property (
      q.period >= ppsc_pkg::PERIOD_MIN && q.period <= ppsc_pkg::PERIOD_MAX)
      else $error("period outside rate range");
   a_ceil_limit: assert property (
      (q.ceil <= ppsc_pkg::DUTY_MAX) and (q.st == ppsc_pkg::ST_RUN |-> duty_eff <= q.ceil))
      else $error("duty above ceiling");
   a_trip_off: assert property (
      dis |=> !q.hi && !q.lo && q.ssd)
      else $error("drives active while disabled");
   a_count_clear: assert property (
      dis |=> q.cnt == '0 && q.st == ppsc_pkg::ST_OFF)
      else $error("hiccup count kept across disable");
   a_side_select: assert property (
      (q.hi |-> $past(q.buck)) and (q.lo |-> !$past(q.buck)))
      else $error("wrong drive side switching");
   a_mode_hold: assert property (
      !rail_rise && !trip_rise |=> $stable(q.buck))
      else $error("topology changed without latch edge");
   a_error_off: assert property (
      q.s2[ppsc_pkg::F_COMP_LO] |=> !q.hi && !q.lo)
      else $error("drives active with error input low");
endmodule : ppsc_control

// [ppsc_control_bench.sv]
`timescale 1ns/1ps
module ppsc_control_bench;
   localparam int P = 1000;
   localparam int LIM = 5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1, over = 1'b0, ss = 1'b1, trip = 1'b1, otemp = 1'b0, topo = 1'b1;
   logic mst = 1'b1, slv = 1'b0, sft = 1'b0, elo = 1'b0, ehi = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, peer_on = 1'b0, clr = 1'b0, low_supply_lock = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
   logic [11:0] peer_half = 12'h1f4;
   logic oe, hs, ls, ssd, hrdy, hresp, share;
   logic [31:0] hs_cnt, ls_cnt, oe_cnt, lag;
   int error_cnt = 0;
   int n_checks = 0;
   int n;
   // Clock
   always #2.5 clk = ~clk;
   // Device under test
   ppsc_control #(.HICCUP_LIMIT(LIM), .HICCUP_CYCLES(LIM)) ppsc_control_i (
      .I_REF_CLK(clk), .I_SYS_RST(rst), .I_ENABLE(en), .I_LOW_SUPPLY_LOCK(low_supply_lock),
      .I_INTERNAL_RAIL_GOOD(1'b1), .I_OVER_LIMIT(over), .I_SS_ABOVE(ss), .I_TRIP_OK(trip),
      .I_OVERTEMP_TRIP(otemp), .I_TOPOLOGY_BUCK(topo), .I_SHARE_CONFIG_MASTER(mst),
      .I_SHARE_CONFIG_SLAVE(slv), .I_SHARE_CONFIG_SHIFT(sft), .I_ERROR_LOW(elo),
      .I_ERROR_HIGH(ehi), .I_SHARE_CLK(share), .O_SHARE_CLK(), .O_SHARE_CLK_OE(oe),
      .O_HIGH_SIDE_DRIVE(hs), .O_LOW_SIDE_DRIVE(ls), .O_SS_DISCHARGE(ssd), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(ppsc_pkg::SIZE_WORD),
      .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy),
      .O_HRESP(hresp));
   // Far side: peer regulator and driver monitor
   ppsc_partner ppsc_partner_i (.i_clk(clk), .i_peer_on(peer_on), .i_peer_half(peer_half),
      .i_clr(clr), .i_share_oe(oe), .i_high(hs), .i_low(ls), .o_share(share),
      .o_hs_cnt(hs_cnt), .o_ls_cnt(ls_cnt), .o_oe_cnt(oe_cnt), .o_lag(lag));

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask : chk

   task automatic tmo(input int k, input int lim);
      if (k >= lim)
      begin
         $display("unexpected wait length expected below %0d seen %0d", lim, k);
         error_cnt++;
         tally_and_finish();
      end
   endtask : tmo

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc

   task automatic rdy();
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (hrdy !== 1'b1 && k < 64);
      tmo(k, 64);
   endtask : rdy

   // One AHB-Lite single word transfer
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      rdy();
      rd = hrdata;
      chk("response", 32'h0, 32'(hresp));
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, st);
   endtask : wr

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, st);
      chk(what, exp, st);
   endtask : rchk

   // Counts over two whole switching periods
   task automatic meas(input logic [31:0] e_hs, input logic [31:0] e_ls, input logic [31:0] e_oe);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(2 * P + 1);
      chk("high side count", e_hs, hs_cnt);
      chk("low side count", e_ls, ls_cnt);
      chk("share pulldown count", e_oe, oe_cnt);
   endtask : meas

   task automatic ssd_wait(input logic lvl, input int lim, output int k);
      k = 0;
      while (ssd !== lvl && k < lim)
      begin
         @(posedge clk);
         k++;
      end
      tmo(k, lim);
   endtask : ssd_wait

   task automatic t_regs();
      rchk("ctrl reset", ppsc_pkg::A_CTRL, 32'h1);
      rchk("period reset", ppsc_pkg::A_PERIOD, 32'h7d0);
      rchk("ceiling reset", ppsc_pkg::A_CEIL, 32'h62);
      rchk("duty reset", ppsc_pkg::A_DUTY, 32'h0);
      rchk("phase reset", ppsc_pkg::A_PHASE, 32'h0);
      rchk("unmapped", 8'h18, 32'h0);
      bus(1'b0, ppsc_pkg::A_STATUS, 32'h0, st);
      chk("buck latch", 32'h1, 32'(st[ppsc_pkg::ST_BUCK]));
      wr(ppsc_pkg::A_PERIOD, 32'h64);
      rchk("period low clamp", ppsc_pkg::A_PERIOD, 32'h29b);
      wr(ppsc_pkg::A_PERIOD, 32'hfff);
      rchk("period high clamp", ppsc_pkg::A_PERIOD, 32'hfa0);
      wr(ppsc_pkg::A_CEIL, 32'h78);
      rchk("ceiling clamp", ppsc_pkg::A_CEIL, 32'h62);
      wr(8'h18, 32'h5);
      wr(ppsc_pkg::A_PERIOD, 32'(P));
      wr(ppsc_pkg::A_DUTY, 32'h32);
   endtask : t_regs

   task automatic t_buck_master();
      cyc(2 * P);
      bus(1'b0, ppsc_pkg::A_STATUS, 32'h0, st);
      chk("state run", 32'h3, 32'(st[1:0]));
      meas(32'(P), 32'h0, 32'(P));
      // Ceiling above the duty command, so only the error-high flag reaches it
      wr(ppsc_pkg::A_CEIL, 32'h46);
      ehi <= 1'b1;
      cyc(P);
      meas(32'(14 * P / 10), 32'h0, 32'(P));
      ehi <= 1'b0;
      elo <= 1'b1;
      wr(ppsc_pkg::A_CEIL, 32'h62);
      cyc(P);
      meas(32'h0, 32'h0, 32'(P));
      elo <= 1'b0;
   endtask : t_buck_master

   task automatic t_trip_boost();
      trip <= 1'b0;
      cyc(10);
      chk("drives in trip", 32'h0, {hs, ls});
      chk("discharge in trip", 32'h1, 32'(ssd));
      topo <= 1'b0;
      rchk("status in trip", ppsc_pkg::A_STATUS, 32'h400c);
      ss <= 1'b0;
      trip <= 1'b1;
      cyc(20);
      bus(1'b0, ppsc_pkg::A_STATUS, 32'h0, st);
      chk("state ramp", 32'h1, 32'(st[1:0]));
      ss <= 1'b1;
      cyc(P);
      meas(32'h0, 32'(P), 32'(P));
      topo <= 1'b1;
      cyc(P);
      meas(32'h0, 32'(P), 32'(P));
   endtask : t_trip_boost

   task automatic t_otemp();
      // Low supply lock is a disable cause of its own
      low_supply_lock <= 1'b1;
      cyc(10);
      rchk("status in low supply", ppsc_pkg::A_STATUS, 32'h4008);
      low_supply_lock <= 1'b0;
      otemp <= 1'b1;
      cyc(10);
      chk("drives in overtemp", 32'h0, {hs, ls});
      chk("discharge in overtemp", 32'h1, 32'(ssd));
      otemp <= 1'b0;
      cyc(20);
      bus(1'b0, ppsc_pkg::A_STATUS, 32'h0, st);
      chk("state after overtemp", 32'h3, 32'(st[1:0]));
   endtask : t_otemp

   task automatic t_hiccup();
      over <= 1'b1;
      cyc(3 * P + P / 2);
      en <= 1'b0;
      cyc(10);
      bus(1'b0, ppsc_pkg::A_STATUS, 32'h0, st);
      chk("count cleared", 32'h0, st & 32'h3ff3);
      en <= 1'b1;
      ssd_wait(1'b0, 100, n);
      ssd_wait(1'b1, 10 * P, n);
      chk("hiccup entry", 32'h1, 32'(n > LIM * P && n <= (LIM + 1) * P + 20));
      cyc(5);
      chk("drives in hiccup", 32'h0, {hs, ls});
      ssd_wait(1'b0, 10 * P, n);
      chk("hiccup length", 32'h1, 32'(n >= LIM * P - 15 && n <= LIM * P + 5));
      over <= 1'b0;
      cyc(20);
      bus(1'b0, ppsc_pkg::A_STATUS, 32'h0, st);
      chk("state after hiccup", 32'h3, 32'(st[1:0]));
   endtask : t_hiccup

   task automatic t_share();
      // Own period 1050 runs slightly slower than the 1000-cycle peer
      wr(ppsc_pkg::A_PERIOD, 32'h41a);
      mst <= 1'b0;
      slv <= 1'b1;
      peer_on <= 1'b1;
      cyc(3 * P);
      // Two locked peer periods, low side on for half of 1050 each
      meas(32'h0, 32'h41a, 32'h0);
      chk("slave lag", 32'h1, 32'(lag >= 1 && lag <= 10));
      wr(ppsc_pkg::A_PHASE, 32'hc8);
      slv <= 1'b0;
      sft <= 1'b1;
      cyc(3 * P);
      meas(32'h0, 32'h41a, 32'h0);
      chk("shift lag", 32'h1, 32'(lag >= 200 && lag <= 212));
   endtask : t_share

   // Main sequence
   initial
   begin
      cyc(8);
      chk("drives in reset", 32'h0, {hs, ls});
      chk("discharge in reset", 32'h1, 32'(ssd));
      rst <= 1'b0;
      cyc(1);
      t_regs();
      t_buck_master();
      t_trip_boost();
      t_otemp();
      t_hiccup();
      t_share();
      tally_and_finish();
   end
endmodule : ppsc_control_bench

// [ppsc_partner.sv]
`timescale 1ns/1ps
// Peer regulator on the share line and a monitor of the gate driver inputs
module ppsc_partner
(
   // Clock
   input wire logic i_clk,
   // Peer clock and measurement control
   input wire logic i_peer_on,
   input wire logic [11:0] i_peer_half,
   input wire logic i_clr,
   // Device pins
   input wire logic i_share_oe,
   input wire logic i_high,
   input wire logic i_low,
   output logic o_share,
   // Measurements
   output logic [31:0] o_hs_cnt,
   output logic [31:0] o_ls_cnt,
   output logic [31:0] o_oe_cnt,
   output logic [31:0] o_lag
);
   logic peer_low = 1'b0;
   logic [11:0] ph = 12'h000;
   logic share_q = 1'b1;
   logic drv_q = 1'b0;
   logic [31:0] since = 32'h0;
   assign o_share = !(i_share_oe || peer_low);
   // Peer rate differs; clock stands still when off
   always @(posedge i_clk)
   begin
      if (!i_peer_on)
      begin
         peer_low <= 1'b0;
         ph <= 12'h000;
      end
      else if (ph == i_peer_half - 12'h001)
      begin
         ph <= 12'h000;
         peer_low <= !peer_low;
      end
      else
         ph <= ph + 12'h001;
   end
   // Drive high-cycle counts, share pulldown cycles and lag from share rise to drive rise
   always @(posedge i_clk)
   begin
      share_q <= o_share;
      drv_q <= i_high || i_low;
      since <= (o_share && !share_q) ? 32'h1 : since + 32'h1;
      if ((i_high || i_low) && !drv_q)
         o_lag <= since;
      if (i_clr)
      begin
         o_hs_cnt <= 32'h0;
         o_ls_cnt <= 32'h0;
         o_oe_cnt <= 32'h0;
      end
      else
      begin
         o_hs_cnt <= o_hs_cnt + 32'(i_high);
         o_ls_cnt <= o_ls_cnt + 32'(i_low);
         o_oe_cnt <= o_oe_cnt + 32'(i_share_oe);
      end
   end
endmodule : ppsc_partner

// [ppsc_pkg.sv]
package ppsc_pkg;
   // Switching clock timing
   localparam int CLK_HZ = 200_000_000;
   localparam int RATE_RESISTOR_PIN_MIN_HZ = 50_000;
   localparam int RATE_RESISTOR_PIN_MAX_HZ = 300_000;
   localparam int RATE_RESISTOR_PIN_DEF_HZ = 100_000;
   localparam int PW = 12;
   localparam logic [PW-1:0] PERIOD_MAX = PW'(CLK_HZ / RATE_RESISTOR_PIN_MIN_HZ);
   localparam logic [PW-1:0] PERIOD_MIN = PW'((CLK_HZ + RATE_RESISTOR_PIN_MAX_HZ - 1) / RATE_RESISTOR_PIN_MAX_HZ);
   localparam logic [PW-1:0] PERIOD_DEF = PW'(CLK_HZ / RATE_RESISTOR_PIN_DEF_HZ);
   // Hiccup counts in switching cycles
   localparam int CW = 10;
   localparam int HICCUP_LIMIT = 500;
   localparam int HICCUP_CYCLES = 500;
   // Duty cycle in percent
   localparam logic [6:0] DUTY_MAX = 7'h62;
   localparam logic [6:0] DUTY_FULL = 7'h64;
   localparam logic [6:0] DUTY_RST = 7'h00;
   localparam logic [PW-1:0] PHASE_RST = 12'h000;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PERIOD = 8'h04;
   localparam logic [7:0] A_CEIL = 8'h08;
   localparam logic [7:0] A_DUTY = 8'h0c;
   localparam logic [7:0] A_PHASE = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   // Status field positions
   localparam int ST_BUCK = 2;
   localparam int ST_MASTER = 3;
   localparam int ST_CNT = 4;
   localparam int ST_DIS = 14;
   // Flag indices of the synchronised inputs
   localparam int F_OVER = 0;
   localparam int F_SS_UP = 1;
   localparam int F_TRIP_OK = 2;
   localparam int F_OTEMP = 3;
   localparam int F_BUCK = 4;
   localparam int F_RAIL = 5;
   localparam int F_SH_MST = 6;
   localparam int F_SH_SLV = 7;
   localparam int F_SH_SFT = 8;
   localparam int F_COMP_LO = 9;
   localparam int F_COMP_HI = 10;
   localparam int F_SYNC = 11;
   localparam int F_EN = 12;
   localparam int NFLAG = 13;
   // Control states, Gray along off, ramp, run, hiccup
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_RAMP = 2'b01,
      ST_RUN = 2'b11,
      ST_HICCUP = 2'b10
   } ppsc_state_t;
   // Clock-share pin roles
   typedef enum logic [1:0] {
      SH_MASTER = 2'b00,
      SH_SLAVE = 2'b01,
      SH_SHIFT = 2'b11
   } ppsc_share_t;
endpackage : ppsc_pkg
